// ### bus_listener.sv
/*
  Listener model for the far side of the bus: three-wire acceptor handshake, byte capture.
  Assumes every line is 1 = true and that all lines are sampled on the rising edge of pclk.
*/
module bus_listener (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Lines from the sequencer, stall from the bench
  input  wire bus_seq_pkg::ctl_lines_t lines,
  input  wire logic [7:0]             dio,
  input  wire logic [7:0]             dio_oe,
  input  wire logic                   stall,
  // Handshake back and captured byte
  output logic                        nrfd,
  output logic                        ndac,
  output logic                        got,
  output logic [9:0]                  got_b
);
  import bus_seq_pkg::*;

  // Acceptor: ready once not stalled, takes the byte on valid, releases on valid low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nrfd  <= 1'b1;
      ndac  <= 1'b1;
      got   <= 1'b0;
      got_b <= '0;
    end else begin
      got <= 1'b0;
      if (lines.dav) begin
        if (!nrfd && ndac) begin
          got   <= 1'b1;
          got_b <= {lines.atn, lines.eoi, dio & dio_oe}; // Undriven lines read false
          nrfd  <= 1'b1;
          ndac  <= 1'b0;
        end
      end else begin
        ndac <= 1'b1;
        if (!stall) nrfd <= 1'b0; // Once ready, stays ready until the byte
      end
    end
  end
endmodule : bus_listener

// ### bus_seq_pkg.sv
/*
  Types shared by the bus sequencer: states, queued bus bytes and control lines.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bus_seq_pkg;

  // --------------------------------------------------------------------------
  // Sequencer states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_ATN    = 7'h02,
    ST_SETTLE = 7'h04,
    ST_WAIT   = 7'h08,
    ST_DAV    = 7'h10,
    ST_IFC    = 7'h20,
    ST_PPOLL  = 7'h40
  } state_t;

  // One queued bus byte: command under attention or data
  typedef struct packed {
    logic       cmd;
    logic       eoi;
    logic [7:0] data;
  } bus_byte_t;

  // Single-line control signals driven onto the bus
  typedef struct packed {
    logic atn;
    logic eoi;
    logic ifc;
    logic ren;
    logic dav;
  } ctl_lines_t;

endpackage : bus_seq_pkg

// ### gpib_controller_bus_sequencer.sv
/*
  Controller-side bus sequencer: APB register file, two-entry byte queue, three-wire
  source handshake, attention handling, interface clear and parallel poll.
  Assumes bus inputs already synchronous to pclk and true = 1 on every line.
*/
// How it works
// - During a poll, drive each data line true whose response bit is one.
// - During a poll, leave false every data line whose response bit is zero.
// - Attention keeps its level until a later step asks for the other one.
// - Attention only toggles when the step needs a different level.
// - Abort as system controller holds interface clear at least 100 us.
// - Single-line messages use control lines; multi-line commands go on data lines.
// - A requested end-or-identify goes out with the next data-out byte.
`include "gpib_seq_consts.svh"

module gpib_controller_bus_sequencer #(
  parameter int unsigned IFC_CYCLES    = `IFC_CYC,
  parameter int unsigned PP_CYCLES     = `PP_CYC,
  parameter int unsigned SETTLE_CYCLES = `SETTLE_CYC
) (
  // Clock, reset, enable
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    ce,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // Bus lines
  output bus_seq_pkg::ctl_lines_t      lines_o,
  output logic [7:0]                   dio_o,
  output logic [7:0]                   dio_oe,
  input  wire logic [7:0]              dio_i,
  input  wire logic                    atn_i,
  input  wire logic                    eoi_i,
  input  wire logic                    nrfd_i,
  input  wire logic                    ndac_i
);
  import bus_seq_pkg::*;

  localparam int CW = 12;
  localparam logic [CW-1:0] IFC_N    = CW'(IFC_CYCLES - 1);
  localparam logic [CW-1:0] PP_N     = CW'(PP_CYCLES - 1);
  localparam logic [CW-1:0] SETTLE_N = CW'(SETTLE_CYCLES - 1);

  // --------------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------------
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [7:0]  ppr_r, ppr_nxt, ppres_r, ppres_nxt;
  logic [3:0]  pend_r, pend_nxt, take;
  logic        eoi_pend_r, eoi_pend_nxt, sysc_r, sysc_nxt;
  logic        sel_ppr, sel_dout, sel_ctrl, sel_cmd, sel_stat, sel_ppres;
  logic        mapped, fill_blk, acc, wr_fire, push, pop;
  bus_byte_t   ent_r [2];
  bus_byte_t   push_ent;
  logic        wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  // Sequencer
  state_t      state_r, state_nxt;
  logic [CW-1:0] tmr_r, tmr_nxt;
  bus_byte_t   cur_r, cur_nxt;
  logic        cur_vld_r, cur_vld_nxt, act_r, act_nxt;
  logic        atn_want_r, atn_want_nxt, atn_save_r, atn_save_nxt;
  ctl_lines_t  lines_r, lines_nxt;
  logic [7:0]  dio_r, dio_nxt, oe_r, oe_nxt;
  logic        in_poll, drv;

  // Address decode, queue back-pressure and read mux
  always_comb begin
    sel_ppr   = (paddr == {`PPR_IDX, 2'b00});
    sel_dout  = (paddr == {`DOUT_IDX, 2'b00});
    sel_ctrl  = (paddr == {`CTRL_IDX, 2'b00});
    sel_cmd   = (paddr == {`CMD_IDX, 2'b00});
    sel_stat  = (paddr == {`STAT_IDX, 2'b00});
    sel_ppres = (paddr == {`PPRES_IDX, 2'b00});
    mapped    = sel_ppr | sel_dout | sel_ctrl | sel_cmd | sel_stat | sel_ppres;
    fill_blk  = pwrite & (sel_dout | sel_cmd) & (cnt_r == 2'd2); // Stall writer while queue full
    acc       = psel & penable & ~pready_r;
    pready_nxt  = acc & ~fill_blk;
    pslverr_nxt = acc & ~fill_blk & ~mapped;
    prdata_nxt  = 32'h0000_0000;
    if (acc && !pwrite) begin
      if (sel_ctrl) begin
        prdata_nxt = {26'h0, sysc_r, eoi_pend_r, pend_r};
      end else if (sel_stat) begin
        prdata_nxt = {24'h0, eoi_pend_r, (state_r != ST_IDLE), (cnt_r == 2'd0), (cnt_r == 2'd2),
                      act_r, lines_r.ren, lines_r.ifc, lines_r.atn};
      end else if (sel_ppres) begin
        prdata_nxt = {24'h0, ppres_r};
      end
    end
  end

  // Register writes and queue filling; a set from software always wins over a clear
  always_comb begin
    wr_fire  = psel & penable & pwrite & pready_r & ~pslverr_r;
    push     = wr_fire & (sel_dout | sel_cmd);
    push_ent = '{cmd: sel_cmd, eoi: eoi_pend_r & sel_dout, data: pwdata[7:0]};
    ppr_nxt  = (wr_fire && sel_ppr) ? pwdata[7:0] : ppr_r;
    sysc_nxt = (wr_fire && sel_ctrl) ? pwdata[`CTRL_SYSC] : sysc_r;
    pend_nxt = (pend_r & ~take) | ((wr_fire && sel_ctrl) ? pwdata[3:0] : 4'h0);
    eoi_pend_nxt = (wr_fire && sel_ctrl && pwdata[`CTRL_EOI]) | (eoi_pend_r & ~(push & sel_dout));
    wp_nxt  = push ? ~wp_r : wp_r;
    rp_nxt  = pop ? ~rp_r : rp_r;
    cnt_nxt = cnt_r + 2'(push) - 2'(pop); // A push and a pop in one cycle cancel
  end

  // Register file state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      ppr_r      <= `PPR_RST;
      sysc_r     <= `SYSC_RST;
      pend_r     <= 4'h0;
      eoi_pend_r <= 1'b0;
      wp_r       <= 1'b0;
      rp_r       <= 1'b0;
      cnt_r      <= 2'd0;
    end else if (ce) begin
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      prdata_r   <= prdata_nxt;
      ppr_r      <= ppr_nxt;
      sysc_r     <= sysc_nxt;
      pend_r     <= pend_nxt;
      eoi_pend_r <= eoi_pend_nxt;
      wp_r       <= wp_nxt;
      rp_r       <= rp_nxt;
      cnt_r      <= cnt_nxt;
    end
  end

  // Queue storage; data needs no reset since the count guards it
  always_ff @(posedge pclk) begin
    if (ce && push) begin
      ent_r[wp_r] <= push_ent;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    tmr_nxt      = tmr_r;
    cur_nxt      = cur_r;
    cur_vld_nxt  = cur_vld_r;
    act_nxt      = act_r;
    atn_want_nxt = atn_want_r;
    atn_save_nxt = atn_save_r;
    lines_nxt    = lines_r;
    ppres_nxt    = ppres_r;
    take         = 4'h0;
    pop          = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (pend_r[`CTRL_ABORT]) begin
          take[`CTRL_ABORT] = 1'b1;
          if (sysc_r) begin
            lines_nxt.ifc = 1'b1;
            tmr_nxt       = IFC_N;
            state_nxt     = ST_IFC;
          end
        end else if (pend_r[`CTRL_PPOLL]) begin
          take[`CTRL_PPOLL] = 1'b1;
          if (act_r) begin
            atn_save_nxt  = lines_r.atn;
            lines_nxt.atn = 1'b1;
            lines_nxt.eoi = 1'b1;
            tmr_nxt       = PP_N;
            state_nxt     = ST_PPOLL;
          end
        end else if (pend_r[`CTRL_GTS] || pend_r[`CTRL_TCA]) begin
          take[`CTRL_GTS] = 1'b1;
          take[`CTRL_TCA] = 1'b1;
          atn_want_nxt    = pend_r[`CTRL_TCA];
          if (pend_r[`CTRL_TCA] != lines_r.atn) begin
            state_nxt = ST_ATN;
          end
        end else if (cnt_r != 2'd0) begin
          pop          = 1'b1;
          cur_nxt      = ent_r[rp_r];
          cur_vld_nxt  = 1'b1;
          atn_want_nxt = ent_r[rp_r].cmd;
          tmr_nxt      = SETTLE_N;
          state_nxt    = (ent_r[rp_r].cmd != lines_r.atn) ? ST_ATN : ST_SETTLE;
        end
      end
      ST_ATN: begin
        lines_nxt.atn = atn_want_r;
        tmr_nxt       = SETTLE_N;
        state_nxt     = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (tmr_r == '0) begin
          state_nxt = cur_vld_r ? ST_WAIT : ST_IDLE;
        end else begin
          tmr_nxt = tmr_r - 12'h001;
        end
      end
      ST_WAIT: begin
        if (!nrfd_i) begin
          lines_nxt.dav = 1'b1;
          lines_nxt.eoi = cur_r.eoi & ~cur_r.cmd;
          state_nxt     = ST_DAV;
        end
      end
      ST_DAV: begin
        if (!ndac_i) begin
          lines_nxt.dav = 1'b0;
          lines_nxt.eoi = 1'b0;
          cur_vld_nxt   = 1'b0;
          state_nxt     = ST_IDLE;
        end
      end
      ST_IFC: begin
        if (tmr_r == '0) begin
          lines_nxt.ifc = 1'b0;
          lines_nxt.ren = 1'b1;
          act_nxt       = 1'b1;
          atn_want_nxt  = 1'b0;
          state_nxt     = lines_r.atn ? ST_ATN : ST_IDLE;
        end else begin
          tmr_nxt = tmr_r - 12'h001;
        end
      end
      ST_PPOLL: begin
        if (tmr_r == '0) begin
          ppres_nxt     = dio_i;
          lines_nxt.eoi = 1'b0;
          atn_want_nxt  = atn_save_r;
          state_nxt     = (atn_save_r != lines_r.atn) ? ST_ATN : ST_IDLE;
        end else begin
          tmr_nxt = tmr_r - 12'h001;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Data line drivers, one per bit: poll response has priority over handshake data
  assign in_poll = (atn_i & eoi_i) | (state_r == ST_PPOLL);
  assign drv     = cur_vld_r & ((state_r == ST_SETTLE) | (state_r == ST_WAIT) | (state_r == ST_DAV));
  for (genvar i = 0; i < 8; i++) begin : g_dio
    assign dio_nxt[i] = in_poll ? ppr_r[i] : (drv & cur_r.data[i]);
    assign oe_nxt[i]  = in_poll ? ppr_r[i] : drv;
  end

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= ST_IDLE;
      tmr_r      <= '0;
      cur_r      <= '0;
      cur_vld_r  <= 1'b0;
      act_r      <= 1'b0;
      atn_want_r <= 1'b0;
      atn_save_r <= 1'b0;
      lines_r    <= '0;
      ppres_r    <= 8'h00;
      dio_r      <= 8'h00;
      oe_r       <= 8'h00;
    end else if (ce) begin
      state_r    <= state_nxt;
      tmr_r      <= tmr_nxt;
      cur_r      <= cur_nxt;
      cur_vld_r  <= cur_vld_nxt;
      act_r      <= act_nxt;
      atn_want_r <= atn_want_nxt;
      atn_save_r <= atn_save_nxt;
      lines_r    <= lines_nxt;
      ppres_r    <= ppres_nxt;
      dio_r      <= dio_nxt;
      oe_r       <= oe_nxt;
    end
  end

  // Outputs straight from flops
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;
  assign lines_o = lines_r;
  assign dio_o   = dio_r;
  assign dio_oe  = oe_r;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [CW-1:0] ifc_len_r;

  // Length of the current interface clear pulse, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifc_len_r <= '0;
    end else if (ce) begin
      ifc_len_r <= !lines_r.ifc ? '0 : ((ifc_len_r == '1) ? ifc_len_r : ifc_len_r + 12'h001);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ready;
    ce && state_r == ST_WAIT && !nrfd_i;
  endsequence

  property p_ppoll_drive;
    ce && in_poll |=> dio_oe == $past(ppr_r) && (dio_o & dio_oe) == dio_oe;
  endproperty
  a_ppoll_drive: assert property (p_ppoll_drive) else $error("poll response not driven");

  property p_ppoll_zero;
    ce && in_poll |=> (dio_o & ~$past(ppr_r)) == 8'h00;
  endproperty
  a_ppoll_zero: assert property (p_ppoll_zero) else $error("zero response bit driven");

  property p_atn_hold;
    ce && (state_r == ST_WAIT || state_r == ST_DAV) |=> $stable(lines_o.atn);
  endproperty
  a_atn_hold: assert property (p_atn_hold) else $error("attention moved during handshake");

  property p_atn_need;
    state_r == ST_ATN |-> lines_o.atn != atn_want_r;
  endproperty
  a_atn_need: assert property (p_atn_need) else $error("needless attention toggle");

  property p_ifc_len;
    $fell(lines_o.ifc) |-> ifc_len_r >= CW'(IFC_CYCLES);
  endproperty
  a_ifc_len: assert property (p_ifc_len) else $error("interface clear too short");

  property p_cmd_atn;
    lines_o.dav |-> lines_o.atn == cur_r.cmd;
  endproperty
  a_cmd_atn: assert property (p_cmd_atn) else $error("byte sent with wrong attention");

  property p_dout;
    s_ready |=> lines_o.dav && dio_o == cur_r.data && dio_oe == 8'hff;
  endproperty
  a_dout: assert property (p_dout) else $error("data byte not presented");

  property p_eoi_next;
    s_ready |=> lines_o.eoi == (cur_r.eoi & ~cur_r.cmd);
  endproperty
  a_eoi_next: assert property (p_eoi_next) else $error("end-or-identify mismatch");

endmodule : gpib_controller_bus_sequencer

// ### gpib_seq_consts.svh
/*
  Offsets, field positions, reset values and timing counts for the bus sequencer.
  Assumes a 40 MHz register clock and word-aligned APB addressing (byte address = index * 4).
*/
`ifndef GPIB_SEQ_CONSTS_SVH
`define GPIB_SEQ_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define PPR_IDX    6'h1d
`define DOUT_IDX   6'h1f
`define CTRL_IDX   6'h20
`define CMD_IDX    6'h21
`define STAT_IDX   6'h22
`define PPRES_IDX  6'h23

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_ABORT 0
`define CTRL_PPOLL 1
`define CTRL_GTS   2
`define CTRL_TCA   3
`define CTRL_EOI   4
`define CTRL_SYSC  5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PPR_RST    8'h00
`define SYSC_RST   1'b0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_NS     25
`define IFC_NS     100000
`define PP_NS      25000
`define SETTLE_NS  2000
`define IFC_CYC    ((`IFC_NS + `CLK_NS - 1) / `CLK_NS)
`define PP_CYC     ((`PP_NS + `CLK_NS - 1) / `CLK_NS)
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ### tb.sv
/*
  Self-checking bench: APB master, random bus stalls, attention, abort and poll checks.
  Assumes the sequencer, its package and constants header, and the listener model.
*/
`include "gpib_seq_consts.svh"

module tb import bus_seq_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------------
  localparam int IFC = 8;
  localparam logic [7:0] A_PPR = {`PPR_IDX, 2'b00}, A_DOUT = {`DOUT_IDX, 2'b00}, A_CTRL = {`CTRL_IDX, 2'b00};
  localparam logic [7:0] A_CMD = {`CMD_IDX, 2'b00}, A_STAT = {`STAT_IDX, 2'b00}, A_PRES = {`PPRES_IDX, 2'b00};
  logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, e, stall = 0, hold = 0;
  logic        pready, pslverr, nrfd, ndac, got, ext_atn = 0, ext_eoi = 0, atn_q = 0, last_c, eoi_pend, c;
  logic [7:0]  paddr = 0, dio_o, dio_oe, ext_dio = 0, b, p;
  logic [31:0] pwdata = 0, prdata, q;
  logic [9:0]  got_b;
  logic [9:0]  rxq[$], expq[$];
  ctl_lines_t  lines_o;
  int          failures = 0, checks = 0, ifc_n = 0, togg = 0, exp_togg = 0, n;
  wire logic [7:0] dio_i = (dio_o & dio_oe) | ext_dio;

  gpib_controller_bus_sequencer #(.IFC_CYCLES(IFC), .PP_CYCLES(4), .SETTLE_CYCLES(2))
    gpib_controller_bus_sequencer_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .lines_o(lines_o), .dio_o(dio_o), .dio_oe(dio_oe),
    .dio_i(dio_i), .atn_i(lines_o.atn | ext_atn), .eoi_i(lines_o.eoi | ext_eoi),
    .nrfd_i(nrfd), .ndac_i(ndac));

  bus_listener bus_listener_inst (.pclk(pclk), .presetn(presetn), .lines(lines_o), .dio(dio_o),
    .dio_oe(dio_oe), .stall(stall), .nrfd(nrfd), .ndac(ndac), .got(got), .got_b(got_b));

  // Clock, random listener stalls, capture, interface-clear and attention monitors
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    stall <= hold | ($urandom_range(3) == 0);
    if (got === 1'b1) rxq.push_back(got_b);
    if (lines_o.ifc === 1'b1) ifc_n++;
    if (lines_o.atn !== atn_q) togg++;
    atn_q <= lines_o.atn;
  end

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 400);
    if (k >= 400) begin failures++; test_done(); end
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  // Expected capture: end-or-identify only rides on data bytes
  function automatic logic [9:0] exp_byte(input logic cm, input logic eo, input logic [7:0] v);
    return {cm, eo & ~cm, v};
  endfunction : exp_byte

  // Queue one byte and work out what the listener must see
  task send(input logic cm, input logic eo, input logic [7:0] v);
    if (eo) apb(1, A_CTRL, 32'h30);
    apb(1, cm ? A_CMD : A_DOUT, {24'h0, v});
    eoi_pend = eoi_pend | eo;
    expq.push_back(exp_byte(cm, eoi_pend, v));
    if (!cm) eoi_pend = 0;
    if (cm != last_c) exp_togg++;
    last_c = cm;
  endtask : send

  task wait_rx(input int k);
    for (n = 0; n < 4000 && rxq.size() < k; n++) @(posedge pclk);
    if (n >= 4000) begin failures++; test_done(); end
  endtask : wait_rx

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h58f8));
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("lines_rst", 0, {lines_o, dio_oe});
    apb(0, A_PPR, 0);
    chk("ppr_rd", 0, q);
    apb(1, A_PPR, 0);
    apb(0, 8'h00, 0);
    chk("slverr", 1, e);
    apb(0, A_STAT, 0);
    chk("stat_rst", 32'h20, q);
    apb(1, A_CTRL, 32'h01);
    repeat (20) @(posedge pclk);
    chk("ifc_nosys", 0, ifc_n);
    apb(1, A_CTRL, 32'h21);
    for (n = 0; n < 300 && !(ifc_n > 0 && lines_o.ifc === 1'b0); n++) @(posedge pclk);
    if (n >= 300) begin failures++; test_done(); end
    chk("ifc_len", IFC, ifc_n);
    apb(0, A_STAT, 0);
    chk("stat_act", 32'h2c, q);
    // Commands hold attention, an end request skips commands, data drops attention
    togg = 0; exp_togg = 0; last_c = 0; eoi_pend = 0;
    send(1, 0, 8'h14);
    send(1, 1, 8'h3f);
    wait_rx(2);
    repeat (12) @(posedge pclk);
    chk("atn_hold", 1, lines_o.atn);
    send(0, 0, 8'ha5);
    send(0, 0, 8'h00);
    send(0, 1, 8'hff);
    hold <= 1;
    fork
      for (int i = 0; i < 16; i++) begin
        c = ($urandom_range(3) == 0);
        send(c, 1'($urandom_range(1)), 8'($urandom));
      end
      begin repeat (80) @(posedge pclk); hold <= 0; end
    join
    wait_rx(21);
    repeat (20) @(posedge pclk);
    while (expq.size() > 0) chk("rx_byte", expq.pop_front(), rxq.pop_front());
    chk("atn_toggles", exp_togg, togg);
    chk("atn_level", last_c, lines_o.atn);
    // Own poll reads the wire, then attention returns to its level
    ext_dio <= 8'($urandom);
    apb(1, A_CTRL, 32'h22);
    for (n = 0; n < 300 && lines_o.eoi !== 1'b1; n++) @(posedge pclk);
    if (n >= 300) begin failures++; test_done(); end
    for (n = 0; n < 300 && lines_o.eoi !== 1'b0; n++) @(posedge pclk);
    if (n >= 300) begin failures++; test_done(); end
    repeat (4) @(posedge pclk);
    chk("poll_atn", last_c, lines_o.atn);
    apb(0, A_PRES, 0);
    chk("poll_byte", {24'h0, ext_dio}, q);
    ext_dio <= 0;
    // Poll response: each set bit driven true, each clear bit left false
    for (int i = 0; i < 6; i++) begin
      p = (i < 4) ? 8'(32'h018000ff >> (8 * i)) : 8'($urandom);
      apb(1, A_PPR, {24'h0, p});
      ext_atn <= 1; ext_eoi <= 1;
      repeat (3) @(posedge pclk);
      chk("ppr_dio", p, dio_o & dio_oe);
      chk("ppr_oe", p, dio_oe);
      ext_atn <= 0; ext_eoi <= 0;
      repeat (3) @(posedge pclk);
      chk("ppr_off", 0, dio_oe);
    end
    apb(1, A_PPR, 0);
    test_done();
  end
endmodule : tb
